//--- hw/hsq_stage_sequencer.sv
// Stage sequencer, fan, occupancy and engineering menu of the thermostat.
// Assumes synchronous inputs and one-cycle write strobes.
//
// Notes on behaviour
// - Auto type changes mode by itself.
// - Manual type changes mode only on button or command.
// - Lock bit 9 gives outputs to supervisor.
// - Other type codes are ignored.
// - Stage changes wait minimum on or off time.
// - Hourly turn-on count caps further turn-ons.
// - Pending flag while a change is held.
// - Stage 2 waits a mode-specific delay after stage 1.
// - Valve open in cooling; polarity inverts.
// - Setpoint entering deadband drags the other.
// - Cool floor: max of low limit plus deadband, minimum.
// - Heat ceiling: min of high limit less deadband, maximum.
// - Assigned temperature used while heartbeat is fresh.
// - Auto fan, lowest stop: runs 2 min after action.
// - Lowest speed low: fan keeps running.
// - Fan mode: auto default, code 2 continuous.
// - Supervisor occupancy counts only with lock bit 6.
// - Set button and supervisor occupancy: last wins; in the same cycle the supervisor write wins.
// - Setpoints follow occupancy state.
// - Up and down held 5 s after reset open menu.
// - Arrows step items with wrap; mode enters, confirms.
// - Idle 10 s leaves edit, then menu; end item exits.
// - Lock bits 0 to 5 lock buttons outside the engineering menu.
`timescale 1ns/100ps
module hsq_stage_sequencer
    import hsq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int MENU_ITEMS = MENU_ITEMS_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire hsq_btn_t buttons,
    input wire logic [15:0] lockWord,
    input wire hsq_cfg_t cfg,
    input wire logic cfgWrite,
    input wire logic systemModeCommand,
    input wire logic systemModeWrite,
    input wire logic [1:0] fanModeSelect,
    input wire logic fanModeWrite,
    input wire logic occupancyCommand,
    input wire logic occupancyWrite,
    input wire logic occupancyContactInput,
    input wire logic heartbeatFlag,
    input wire hsq_temp_t assignedTemperature,
    input wire hsq_temp_t onboardTemperature,
    input wire hsq_temp_t spValue,
    input wire logic spWriteCool,
    input wire logic spWriteHeat,
    input wire hsq_drv_t supDrive,
    output hsq_drv_t drive,
    output logic pendingIcon,
    output logic fanDelayFlash,
    output logic coolMode,
    output logic systemOn,
    output logic occupancyStateReadback,
    output hsq_temp_t activeTemperature,
    output hsq_temp_t coolSetpoint,
    output hsq_temp_t heatSetpoint,
    output hsq_menu_t menuState,
    output logic [7:0] menuItem,
    output logic [7:0] menuValue,
    output logic menuApply
);

    // ==========
    // Helpers
    function automatic hsq_temp_t tMax(hsq_temp_t a, hsq_temp_t b);
        return (a > b) ? a : b;
    endfunction : tMax

    function automatic hsq_temp_t tMin(hsq_temp_t a, hsq_temp_t b);
        return (a < b) ? a : b;
    endfunction : tMin

    function automatic logic [15:0] satInc(logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : satInc

    // ==========
    // One-second tick
    logic [31:0] preCnt_reg;
    logic tick;

    always_ff @(posedge clk) begin
        if (rst) begin
            preCnt_reg <= '0;
            tick <= 1'b0;
        end else if (clkEn) begin
            tick <= (preCnt_reg == 32'(TICK_CYCLES - 1));
            preCnt_reg <= (preCnt_reg == 32'(TICK_CYCLES - 1)) ?
                '0 : preCnt_reg + 32'h1;
        end
    end

    // ==========
    // Buttons and configuration registers
    hsq_btn_t btnPrev_reg;
    hsq_btn_t press;
    hsq_btn_t userPress;
    logic netOwn;
    logic [2:0] ctype_reg;
    logic [15:0] coolDelay_reg;
    logic [15:0] heatDelay_reg;
    hsq_temp_t minCool_reg;
    hsq_temp_t maxHeat_reg;

    assign press = buttons & ~btnPrev_reg;
    assign userPress = (menuState == MS_USER) ?
        (press & ~lockWord[LOCK_BTN_HI:0]) : '0;
    assign netOwn = lockWord[LOCK_NET_OUT_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            btnPrev_reg <= '0;
            ctype_reg <= CT_AUTO;
            coolDelay_reg <= 16'(STAGE2_DELAY_S);
            heatDelay_reg <= 16'(STAGE2_DELAY_S);
            minCool_reg <= MIN_COOL_SP_DEF;
            maxHeat_reg <= MAX_HEAT_SP_DEF;
        end else if (clkEn) begin
            btnPrev_reg <= buttons;
            if (cfg.controlTypeSelect == CT_AUTO ||
                cfg.controlTypeSelect == CT_MANUAL) begin
                ctype_reg <= cfg.controlTypeSelect;
            end
            if (cfgWrite) begin
                coolDelay_reg <= cfg.coolSecondStageDelay;
                heatDelay_reg <= cfg.heatSecondStageDelay;
                minCool_reg <= cfg.minCoolingSetpoint;
                maxHeat_reg <= cfg.maxHeatingSetpoint;
            end
        end
    end

    // ==========
    // Setpoints and occupancy
    hsq_temp_t occCool_reg;
    hsq_temp_t occHeat_reg;
    hsq_temp_t occCool_next;
    hsq_temp_t occHeat_next;
    hsq_temp_t coolFloor;
    hsq_temp_t heatCeil;

    assign coolFloor = tMax(hsq_temp_t'(cfg.spLowLimit +
        cfg.minimumDeadband), minCool_reg);
    assign heatCeil = tMin(hsq_temp_t'(cfg.spHighLimit -
        cfg.minimumDeadband), maxHeat_reg);

    always_comb begin
        occCool_next = occCool_reg;
        occHeat_next = occHeat_reg;
        if (spWriteCool) begin
            occCool_next = tMax(spValue, coolFloor);
            if (hsq_temp_t'(occCool_next - occHeat_reg) <
                cfg.minimumDeadband) begin
                occHeat_next = tMin(hsq_temp_t'(occCool_next -
                    cfg.minimumDeadband), heatCeil);
            end
        end else if (spWriteHeat) begin
            occHeat_next = tMin(spValue, heatCeil);
            if (hsq_temp_t'(occCool_reg - occHeat_next) <
                cfg.minimumDeadband) begin
                occCool_next = tMax(hsq_temp_t'(occHeat_next +
                    cfg.minimumDeadband), coolFloor);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            occCool_reg <= OCC_COOL_DEF;
            occHeat_reg <= OCC_HEAT_DEF;
            occupancyStateReadback <= 1'b0;
            coolSetpoint <= OCC_COOL_DEF;
            heatSetpoint <= OCC_HEAT_DEF;
        end else if (clkEn) begin
            occCool_reg <= occCool_next;
            occHeat_reg <= occHeat_next;
            if (!lockWord[LOCK_CONTACT_BIT]) begin
                occupancyStateReadback <= occupancyContactInput;
            end else if (occupancyWrite) begin
                occupancyStateReadback <= occupancyCommand;
            end else if (userPress.set) begin
                occupancyStateReadback <= ~occupancyStateReadback;
            end
            coolSetpoint <= occupancyStateReadback ?
                cfg.unoccupiedCoolSetpoint : occCool_reg;
            heatSetpoint <= occupancyStateReadback ?
                cfg.unoccupiedHeatSetpoint : occHeat_reg;
        end
    end

    // ==========
    // Heartbeat-qualified temperature
    logic hbPrev_reg;
    logic hbSeen_reg;
    logic [15:0] hbSecs_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            hbPrev_reg <= 1'b0;
            hbSeen_reg <= 1'b0;
            hbSecs_reg <= '0;
            activeTemperature <= '0;
        end else if (clkEn) begin
            hbPrev_reg <= heartbeatFlag;
            if (heartbeatFlag != hbPrev_reg) begin
                hbSeen_reg <= 1'b1;
                hbSecs_reg <= '0;
            end else if (tick) begin
                hbSecs_reg <= satInc(hbSecs_reg);
            end
            activeTemperature <= (hbSeen_reg &&
                hbSecs_reg < cfg.heartbeatPeriod) ?
                assignedTemperature : onboardTemperature;
        end
    end

    // ==========
    // Mode selection and stage sequencing
    logic [NUM_STAGES-1:0] stage_reg;
    logic [NUM_STAGES-1:0] stage_next;
    logic [NUM_STAGES-1:0] want;
    logic [15:0] stageSecs_reg [NUM_STAGES];
    logic [11:0] hourSecs_reg;
    logic [7:0] cycles_reg;
    logic pending_next;
    logic turnOn;
    logic dem1;
    logic dem2;
    logic [15:0] delayS;

    assign dem1 = coolMode ? (activeTemperature >= coolSetpoint) :
        (activeTemperature <= heatSetpoint);
    assign dem2 = coolMode ?
        (activeTemperature >= hsq_temp_t'(coolSetpoint + cfg.stageWidth)) :
        (activeTemperature <= hsq_temp_t'(heatSetpoint - cfg.stageWidth));
    assign delayS = coolMode ? coolDelay_reg : heatDelay_reg;
    assign want[0] = dem1 & systemOn;
    assign want[1] = dem1 & dem2 & systemOn & stage_reg[0] &
        (stageSecs_reg[0] >= delayS);

    always_comb begin
        stage_next = stage_reg;
        pending_next = 1'b0;
        turnOn = 1'b0;
        if (netOwn) begin
            stage_next = {supDrive.stage2, supDrive.stage1};
        end else begin
            for (int s = 0; s < NUM_STAGES; s++) begin
                if (want[s] != stage_reg[s]) begin
                    if (stage_reg[s] ? (stageSecs_reg[s] >= cfg.minOnS) :
                        (stageSecs_reg[s] >= cfg.minOffS &&
                        cycles_reg < cfg.maxCycles)) begin
                        stage_next[s] = want[s];
                        turnOn = turnOn | want[s];
                    end else begin
                        pending_next = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            coolMode <= 1'b1;
            systemOn <= 1'b1;
        end else if (clkEn) begin
            if (userPress.power) begin
                systemOn <= ~systemOn;
            end
            if (ctype_reg == CT_AUTO) begin
                if (tick && stage_reg == '0) begin
                    if (activeTemperature >= coolSetpoint) begin
                        coolMode <= 1'b1;
                    end else if (activeTemperature <= heatSetpoint) begin
                        coolMode <= 1'b0;
                    end
                end
            end else if (systemModeWrite) begin
                coolMode <= systemModeCommand;
            end else if (userPress.mode) begin
                coolMode <= ~coolMode;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_reg <= '0;
            pendingIcon <= 1'b0;
            hourSecs_reg <= '0;
            cycles_reg <= '0;
            for (int s = 0; s < NUM_STAGES; s++) begin
                stageSecs_reg[s] <= '0;
            end
        end else if (clkEn && tick) begin
            stage_reg <= stage_next;
            pendingIcon <= pending_next;
            for (int s = 0; s < NUM_STAGES; s++) begin
                stageSecs_reg[s] <= (stage_next[s] != stage_reg[s]) ?
                    '0 : satInc(stageSecs_reg[s]);
            end
            if (hourSecs_reg == HOUR_S - 12'h001) begin
                hourSecs_reg <= '0;
                cycles_reg <= turnOn ? 8'h01 : 8'h00;
            end else begin
                hourSecs_reg <= hourSecs_reg + 12'h001;
                if (turnOn) begin
                    cycles_reg <= cycles_reg + 8'h01;
                end
            end
        end
    end

    // ==========
    // Fan and output drive
    logic fanAuto_reg;
    logic fanRan_reg;
    logic [15:0] fanDelay_reg;
    logic fanDemand;

    assign fanDemand = |stage_reg & (coolMode | cfg.heatingFanEnable);

    always_ff @(posedge clk) begin
        if (rst) begin
            fanAuto_reg <= 1'b1;
        end else if (clkEn) begin
            if (fanModeWrite && fanModeSelect == FAN_AUTO) begin
                fanAuto_reg <= 1'b1;
            end else if (fanModeWrite && fanModeSelect == FAN_CONT) begin
                fanAuto_reg <= 1'b0;
            end else if (userPress.fan) begin
                fanAuto_reg <= ~fanAuto_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drive <= '0;
            fanDelayFlash <= 1'b0;
            fanRan_reg <= 1'b0;
            fanDelay_reg <= '0;
        end else if (clkEn && tick) begin
            fanDelayFlash <= 1'b0;
            if (fanDemand) begin
                fanRan_reg <= 1'b1;
                fanDelay_reg <= 16'(FAN_OFF_DELAY_S);
            end else if (fanDelay_reg != '0) begin
                fanDelay_reg <= fanDelay_reg - 16'h0001;
            end
            drive.stage1 <= stage_next[0];
            drive.stage2 <= stage_next[1];
            drive.valve <= netOwn ? supDrive.valve :
                (coolMode ^ cfg.valvePolaritySelect);
            if (netOwn) begin
                drive.fan <= supDrive.fan;
            end else if (!fanAuto_reg || fanDemand) begin
                drive.fan <= 1'b1;
            end else if (cfg.lowestFanSpeed == LOWEST_LOW) begin
                drive.fan <= fanRan_reg;
            end else if (cfg.lowestFanSpeed == LOWEST_STOP &&
                fanDelay_reg != '0) begin
                drive.fan <= 1'b1;
                fanDelayFlash <= 1'b1;
            end else begin
                drive.fan <= 1'b0;
            end
        end
    end

    // ==========
    // Engineering menu
    logic engArm_reg;
    logic [2:0] holdSecs_reg;
    logic [3:0] idleSecs_reg;
    logic anyPress;
    logic idleOut;

    assign anyPress = |press;
    assign idleOut = tick && idleSecs_reg == MENU_IDLE_S - 4'h1;

    always_ff @(posedge clk) begin
        if (rst) begin
            engArm_reg <= 1'b1;
            holdSecs_reg <= '0;
            idleSecs_reg <= '0;
            menuState <= MS_USER;
            menuItem <= '0;
            menuValue <= '0;
            menuApply <= 1'b0;
        end else if (clkEn) begin
            menuApply <= 1'b0;
            if (anyPress || idleOut) begin
                idleSecs_reg <= '0;
            end else if (tick) begin
                idleSecs_reg <= idleSecs_reg + 4'h1;
            end
            if (!(buttons.up && buttons.down)) begin
                engArm_reg <= 1'b0;
            end else if (engArm_reg && tick) begin
                holdSecs_reg <= holdSecs_reg + 3'h1;
                if (holdSecs_reg == ENG_HOLD_S - 3'h1) begin
                    engArm_reg <= 1'b0;
                    menuState <= MS_SELECT;
                    menuItem <= '0;
                end
            end
            unique case (menuState)
                MS_USER: begin
                end
                MS_SELECT: begin
                    if (press.up) begin
                        menuItem <= (menuItem == 8'(MENU_ITEMS - 1)) ?
                            8'h00 : menuItem + 8'h01;
                    end else if (press.down) begin
                        menuItem <= (menuItem == 8'h00) ?
                            8'(MENU_ITEMS - 1) : menuItem - 8'h01;
                    end else if (press.mode) begin
                        menuState <= (menuItem == 8'(MENU_ITEMS - 1)) ?
                            MS_USER : MS_EDIT;
                    end else if (idleOut) begin
                        menuState <= MS_USER;
                    end
                end
                MS_EDIT: begin
                    if (press.up) begin
                        menuValue <= menuValue + 8'h01;
                    end else if (press.down) begin
                        menuValue <= menuValue - 8'h01;
                    end else if (press.mode) begin
                        menuApply <= 1'b1;
                        menuState <= MS_SELECT;
                    end else if (idleOut) begin
                        menuState <= MS_SELECT;
                    end
                end
            endcase
        end
    end

endmodule : hsq_stage_sequencer

//--- hw/hsq_pkg.sv
// Constants and carrier types for the heat-pump stage sequencer.
// Assumes a 125 MHz clock and temperatures in tenths of a degree.
package hsq_pkg;

    // ==========
    // Timebase
    localparam int CLK_HZ = 125000000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_S;
    localparam int SECS_PER_MIN = 60;
    localparam logic [11:0] HOUR_S = 12'he10;
    localparam int STAGE2_DELAY_MIN = 5;
    localparam int STAGE2_DELAY_S = STAGE2_DELAY_MIN * SECS_PER_MIN;
    localparam int FAN_OFF_DELAY_MIN = 2;
    localparam int FAN_OFF_DELAY_S = FAN_OFF_DELAY_MIN * SECS_PER_MIN;
    localparam logic [2:0] ENG_HOLD_S = 3'h5;
    localparam logic [3:0] MENU_IDLE_S = 4'ha;
    localparam int MENU_ITEMS_DEF = 16;
    localparam int NUM_STAGES = 2;

    // ==========
    // Lock word layout
    localparam int LOCK_BTN_HI = 5;
    localparam int LOCK_CONTACT_BIT = 6;
    localparam int LOCK_NET_OUT_BIT = 9;

    // ==========
    // Codes and reset values
    localparam logic [2:0] CT_AUTO = 3'h0;
    localparam logic [2:0] CT_MANUAL = 3'h1;
    localparam logic [1:0] FAN_AUTO = 2'h1;
    localparam logic [1:0] FAN_CONT = 2'h2;
    localparam logic [1:0] LOWEST_STOP = 2'h1;
    localparam logic [1:0] LOWEST_LOW = 2'h2;
    localparam logic [15:0] MIN_COOL_SP_DEF = 16'h00b4;
    localparam logic [15:0] MAX_HEAT_SP_DEF = 16'h00fa;
    localparam logic [15:0] OCC_COOL_DEF = 16'h00f0;
    localparam logic [15:0] OCC_HEAT_DEF = 16'h00c8;

    typedef logic signed [15:0] hsq_temp_t;

    // Bit 0 is mode, as in the lock word.
    typedef struct packed {
        logic set;
        logic power;
        logic fan;
        logic up;
        logic down;
        logic mode;
    } hsq_btn_t;

    typedef struct packed {
        logic fan;
        logic valve;
        logic stage2;
        logic stage1;
    } hsq_drv_t;

    typedef struct packed {
        logic [2:0] controlTypeSelect;
        logic [1:0] lowestFanSpeed;
        logic valvePolaritySelect;
        logic heatingFanEnable;
        logic [15:0] heartbeatPeriod;
        logic [15:0] minOnS;
        logic [15:0] minOffS;
        logic [7:0] maxCycles;
        hsq_temp_t minimumDeadband;
        hsq_temp_t spLowLimit;
        hsq_temp_t spHighLimit;
        hsq_temp_t unoccupiedCoolSetpoint;
        hsq_temp_t unoccupiedHeatSetpoint;
        hsq_temp_t stageWidth;
        logic [15:0] coolSecondStageDelay;
        logic [15:0] heatSecondStageDelay;
        hsq_temp_t minCoolingSetpoint;
        hsq_temp_t maxHeatingSetpoint;
    } hsq_cfg_t;

    typedef enum logic [1:0] {MS_USER, MS_SELECT, MS_EDIT} hsq_menu_t;

endpackage : hsq_pkg

//--- test/hsq_sup_model.sv
// Network supervisor model: heartbeat toggling and occupancy writes.
// Assumes the bench enables the heartbeat.
`timescale 1ns/100ps
module hsq_sup_model (
    input wire logic clk,
    input wire logic hbOn,
    output logic heartbeatFlag,
    output logic occupancyCommand,
    output logic occupancyWrite
);
    int n = 0;
    initial begin
        heartbeatFlag = 0;
        occupancyCommand = 0;
        occupancyWrite = 0;
    end
    // Toggles every two ticks.
    always @(posedge clk) begin
        #1;
        n++;
        if (hbOn && n % 20 == 0) heartbeatFlag = !heartbeatFlag;
    end
    task setOcc(input logic v);
        occupancyCommand = v;
        occupancyWrite = 1;
        @(posedge clk);
        #1;
        occupancyWrite = 0;
    endtask : setOcc
endmodule : hsq_sup_model

//--- test/hsq_stage_sequencer_sva.sv
// Port checker of the stage sequencer.
// Assumes configuration limits change rarely.
`timescale 1ns/100ps
module hsq_stage_sequencer_sva
    import hsq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [15:0] lockWord,
    input wire hsq_cfg_t cfg,
    input wire hsq_btn_t buttons,
    input wire logic occupancyCommand,
    input wire logic occupancyWrite,
    input wire hsq_drv_t supDrive,
    input wire hsq_drv_t drive,
    input wire logic coolMode,
    input wire logic occupancyStateReadback,
    input wire hsq_temp_t coolSetpoint,
    input wire hsq_temp_t heatSetpoint,
    input wire hsq_menu_t menuState,
    input wire logic menuApply
);
    // ========
    // Assertions
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_valve_level: assert property (
        $changed(drive.valve) && !$past(lockWord[9]) |->
        drive.valve == ($past(coolMode) ^ $past(cfg.valvePolaritySelect))
    ) else $error("valve level");
    a_sup_copy: assert property (
        $changed(drive) && lockWord[9] && $past(lockWord[9]) |->
        drive == $past(supDrive)
    ) else $error("supervisor copy");
    a_cool_floor: assert property (
        $stable(cfg) [*3] |->
        coolSetpoint >= cfg.spLowLimit + cfg.minimumDeadband
    ) else $error("cool floor");
    a_heat_ceiling: assert property (
        $stable(cfg) [*3] |->
        heatSetpoint <= cfg.spHighLimit - cfg.minimumDeadband
    ) else $error("heat ceiling");
    a_deadband_kept: assert property (
        $stable(cfg) [*3] ##0 $stable(coolSetpoint) [*2] ##0
        $stable(heatSetpoint) |->
        coolSetpoint - heatSetpoint >= cfg.minimumDeadband
    ) else $error("deadband");
    a_occ_write: assert property (
        occupancyWrite && clkEn && lockWord[6] |=>
        occupancyStateReadback == $past(occupancyCommand)
    ) else $error("occupancy write");
    a_apply_pulse: assert property (
        menuApply |-> $past(menuState) == MS_EDIT &&
        menuState == MS_SELECT ##1 !menuApply
    ) else $error("apply pulse");
    a_menu_entry: assert property (
        menuState == MS_SELECT && $past(menuState) == MS_USER |->
        $past(buttons.up) && $past(buttons.down)
    ) else $error("menu entry");
endmodule : hsq_stage_sequencer_sva
bind hsq_stage_sequencer hsq_stage_sequencer_sva i_sva(.*);

//--- test/hsq_stage_sequencer_tb.sv
// Directed bench of the stage sequencer with a supervisor model.
// Assumes a ten-cycle tick.
`timescale 1ns/100ps
module hsq_stage_sequencer_tb;
    import hsq_pkg::*;
    localparam int TK = 10;
    logic clk, rst, clkEn, cfgWrite, systemModeCommand, systemModeWrite;
    logic fanModeWrite, occupancyCommand, occupancyWrite, heartbeatFlag;
    logic occupancyContactInput, spWriteCool, spWriteHeat, pendingIcon;
    logic fanDelayFlash, coolMode, systemOn, occupancyStateReadback;
    logic menuApply, hbOn;
    logic [15:0] lockWord;
    logic [1:0] fanModeSelect;
    logic [7:0] menuItem, menuValue;
    hsq_btn_t buttons;
    hsq_cfg_t cfg;
    hsq_drv_t supDrive, drive;
    hsq_menu_t menuState;
    hsq_temp_t assignedTemperature, onboardTemperature, spValue;
    hsq_temp_t activeTemperature, coolSetpoint, heatSetpoint;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    hsq_stage_sequencer #(.TICK_CYCLES(TK), .MENU_ITEMS(16)) i_dut(.*);
    hsq_sup_model i_sup(.clk(clk), .hbOn(hbOn), .heartbeatFlag(heartbeatFlag),
        .occupancyCommand(occupancyCommand), .occupancyWrite(occupancyWrite));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 9000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task chkb(input string nm, input logic e, input logic g);
        chkw(nm, 16'(e), 16'(g));
    endtask : chkb
    task chkw(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chkw
    task press(input int b);
        buttons = hsq_btn_t'(6'h01 << b);
        cyc(2);
        buttons = '0;
        cyc(2);
    endtask : press
    task spw(input logic c, input hsq_temp_t v);
        spValue = v;
        spWriteCool = c;
        spWriteHeat = !c;
        cyc(1);
        {spWriteCool, spWriteHeat} = 2'h0;
        cyc(3);
    endtask : spw
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst, clkEn, buttons} = 8'hc6;
        {cfgWrite, systemModeCommand, systemModeWrite, fanModeWrite} = 4'h0;
        {occupancyContactInput, spWriteCool, spWriteHeat, hbOn} = 4'h0;
        {lockWord, fanModeSelect, supDrive, spValue} = '0;
        assignedTemperature = 16'h00e6;
        onboardTemperature = 16'h00dc;
        cfg = '{lowestFanSpeed: LOWEST_STOP, heatingFanEnable: 1'h1,
            heartbeatPeriod: 16'h0005, minOnS: 16'h0003, minOffS: 16'h0003,
            maxCycles: 8'h02, minimumDeadband: 16'h0014, spLowLimit: 16'h0064,
            spHighLimit: 16'h012c, unoccupiedCoolSetpoint: 16'h0118,
            unoccupiedHeatSetpoint: 16'h0096, stageWidth: 16'h000f,
            coolSecondStageDelay: 16'h0004, heatSecondStageDelay: 16'h0004,
            minCoolingSetpoint: MIN_COOL_SP_DEF,
            maxHeatingSetpoint: MAX_HEAT_SP_DEF, default: '0};
        cyc(2);
        rst = 0;
        chkw("coolSp", OCC_COOL_DEF, coolSetpoint);
        cyc(7 * TK);
        chkb("select", 1, menuState == MS_SELECT);
        buttons = '0;
        cyc(2);
        press(1);
        chkw("item", 16'h000f, 16'(menuItem));
        press(2);
        press(0);
        chkb("edit", 1, menuState == MS_EDIT);
        press(2);
        press(0);
        chkb("apply", 1, menuState == MS_SELECT);
        press(0);
        cyc(12 * TK);
        chkb("abandon", 1, menuState == MS_SELECT);
        cyc(12 * TK);
        chkb("user", 1, menuState == MS_USER);
        $display("test menu done");
        cyc(2 * TK);
        chkw("onboard", 16'h00dc, activeTemperature);
        hbOn = 1;
        cyc(6 * TK);
        chkw("assigned", 16'h00e6, activeTemperature);
        hbOn = 0;
        cyc(8 * TK);
        chkw("revert", 16'h00dc, activeTemperature);
        $display("test heartbeat done");
        occupancyContactInput = 1;
        cyc(4);
        chkb("occ", 1, occupancyStateReadback);
        chkw("unoccCool", 16'h0118, coolSetpoint);
        chkw("unoccHeat", 16'h0096, heatSetpoint);
        i_sup.setOcc(0);
        cyc(2);
        chkb("refused", 1, occupancyStateReadback);
        lockWord = 16'h0040;
        cyc(2);
        i_sup.setOcc(0);
        cyc(3);
        chkw("occCool", OCC_COOL_DEF, coolSetpoint);
        spw(1, 16'h00d2);
        chkw("dragHeat", 16'h00be, heatSetpoint);
        spw(1, 16'h0064);
        chkw("floor", MIN_COOL_SP_DEF, coolSetpoint);
        spw(1, OCC_COOL_DEF);
        spw(0, OCC_HEAT_DEF);
        $display("test setpoint done");
        cfgWrite = 1;
        cyc(1);
        cfgWrite = 0;
        onboardTemperature = 16'h012c;
        for (int i = 0; i < 99 && drive.stage1 !== 1'b1; i++) cyc(1);
        chkb("valve", 1, drive.valve);
        cyc(2 * TK + 5);
        chkb("early2", 0, drive.stage2);
        cyc(4 * TK);
        chkb("stage2", 1, drive.stage2);
        onboardTemperature = 16'h00dc;
        cyc(4 * TK);
        chkb("off", 0, drive.stage1);
        chkb("flash", 1, fanDelayFlash);
        chkb("fanOn", 1, drive.fan);
        cyc(125 * TK);
        chkb("fanOff", 0, drive.fan);
        onboardTemperature = 16'h012c;
        cyc(6 * TK);
        chkb("blocked", 0, drive.stage1);
        chkb("pending", 1, pendingIcon);
        onboardTemperature = 16'h0096;
        cyc(3 * TK);
        chkb("heatMode", 0, coolMode);
        chkb("valveHeat", 0, drive.valve);
        $display("test stages done");
        cfg.controlTypeSelect = CT_MANUAL;
        cyc(1);
        systemModeCommand = 1;
        systemModeWrite = 1;
        cyc(1);
        systemModeWrite = 0;
        cfg.controlTypeSelect = 3'h2;
        cyc(3 * TK);
        chkb("manual", 1, coolMode);
        fanModeSelect = FAN_CONT;
        fanModeWrite = 1;
        cyc(1);
        fanModeWrite = 0;
        cyc(2 * TK);
        chkb("fanCont", 1, drive.fan);
        supDrive = 4'hb;
        lockWord = 16'h0240;
        cyc(2 * TK);
        chkw("supDrive", 16'h000b, 16'(drive));
        $display("test supervisor done");
        tally_and_finish();
    end
endmodule : hsq_stage_sequencer_tb
